// ==== rtl/sync_serial_tx_unit.sv ====
// Synchronous serial transmit unit with APB register access.
// Assumes pclk at 250 MHz, halt_in from core logic on pclk,
// and pins resolved outside from the active-low output enables.
//
// Contract
// - sync plus master bit selects bus master
// - sync with master bit clear takes pin clock
// - transmit only while both receive enables clear
// - unit works only with port enable set
// - characters carry data bits, no framing
// - master drives clock pin, driver auto enabled
// - data changes on leading clock edge
// - one clock cycle per data bit only
// - master transmit drives data pin automatically
// - buffer write starts; waits while shifter busy
// - empty shifter loads at once, then shifts
// - bit held from leading edge to next
// - shift register has no software access
// - slave transmit matches master except halt
// - halt slave: second byte waits, flag later
// - flag during halt wakes; routine needs global
// - nine-bit mode sends ninth bit as MSB
// - transmission only while transmit enable set
// - slave shifts only on master clock
// - shared data line never transmit and receive
`timescale 1ns/1ps
module sync_serial_tx_unit
  import sst_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        halt_in,
  output logic             wake_out,
  output logic             isr_call_out,
  input  wire logic        clock_pin_in,
  output logic             clock_pin_out,
  output logic             clock_pin_oe_n,
  input  wire logic        data_pin_in,
  output logic             data_pin_out,
  output logic             data_pin_oe_n
);
  import sst_pkg::*;

  // ==========================================================
  // Configuration registers
  logic [7:0] tx_status_reg;
  logic [7:0] rx_status_reg;
  logic [7:0] baud_divisor_reg;
  logic [2:0] wake_ctrl_reg;

  wire clock_source_master         = tx_status_reg[TXS_CLOCK_SOURCE_MASTER];
  wire nine_bit_transmit_select    = tx_status_reg[TXS_NINE_BIT_SELECT];
  wire transmit_enable             = tx_status_reg[TXS_TRANSMIT_ENABLE];
  wire sync_mode                   = tx_status_reg[TXS_SYNC_MODE];
  wire high_baud_select            = tx_status_reg[TXS_HIGH_BAUD_SELECT];
  wire ninth_transmit_bit          = tx_status_reg[TXS_NINTH_BIT];
  wire serial_port_enable          = rx_status_reg[RXS_SERIAL_PORT_ENABLE];
  wire single_receive_enable       = rx_status_reg[RXS_SINGLE_RX_ENABLE];
  wire continuous_receive_enable   = rx_status_reg[RXS_CONT_RX_ENABLE];
  wire transmit_interrupt_enable   = wake_ctrl_reg[WKC_TX_INT_ENABLE];
  wire peripheral_interrupt_enable = wake_ctrl_reg[WKC_PERIPH_INT_ENABLE];
  wire global_interrupt_enable     = wake_ctrl_reg[WKC_GLOBAL_INT_ENABLE];

  // ==========================================================
  // Mode decode
  wire unit_on      = serial_port_enable & sync_mode;
  wire receive_mode = single_receive_enable | continuous_receive_enable;
  wire transmit_mode = unit_on & ~receive_mode;
  wire tx_on        = transmit_mode & transmit_enable;
  wire is_master    = clock_source_master;

  // ==========================================================
  // APB decode
  wire setup_phase = psel & ~penable;
  wire access_wr   = psel & penable & pwrite;
  wire hit_txs     = (paddr == OFS_TX_STATUS_CONTROL);
  wire hit_rxs     = (paddr == OFS_RX_STATUS_CONTROL);
  wire hit_tbuf    = (paddr == OFS_TRANSMIT_BUFFER);
  wire hit_baud    = (paddr == OFS_BAUD_DIVISOR);
  wire hit_wake    = (paddr == OFS_WAKE_CONTROL);
  wire mapped      = hit_txs | hit_rxs | hit_tbuf | hit_baud | hit_wake;
  wire wr_txs      = access_wr & hit_txs;
  wire wr_rxs      = access_wr & hit_rxs;
  wire wr_tbuf     = access_wr & hit_tbuf;
  wire wr_baud     = access_wr & hit_baud;
  wire wr_wake     = access_wr & hit_wake;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ==========================================================
  // Transmit path state
  logic [8:0] tbuf_reg;
  logic       tbuf_full_reg;
  logic [8:0] tsr_reg;
  logic       tsr_busy_reg;
  logic       started_reg;
  logic [3:0] bit_cnt_reg;
  logic       flag_last_reg;
  logic       wake_reg;
  logic       isr_call_reg;
  logic [31:0] prdata_reg;

  wire       transmit_buffer_empty_flag = ~tbuf_full_reg;
  wire       shift_register_empty       = ~tsr_busy_reg;
  wire [3:0] char_bits = nine_bit_transmit_select ? BITS_NINE : BITS_NORMAL;
  wire       load_tsr  = tx_on & tbuf_full_reg & ~tsr_busy_reg;
  wire [3:0] bit_cnt_next = bit_cnt_reg + 4'h1;

  // ==========================================================
  // Shift clock unit
  shift_clock_if sc_bus ();

  assign sc_bus.master    = is_master;
  assign sc_bus.busy      = tsr_busy_reg & tx_on;
  assign sc_bus.halt      = halt_in;
  assign sc_bus.high_baud = high_baud_select;
  assign sc_bus.divisor   = baud_divisor_reg;

  shift_clock_unit u_clock
  (
    .pclk         (pclk),
    .presetn      (presetn),
    .clock_pin_in (clock_pin_in),
    .sc           (sc_bus.clk_side)
  );

  wire lead_edge  = sc_bus.lead & tsr_busy_reg & tx_on;
  wire trail_edge = sc_bus.trail & tsr_busy_reg & tx_on;
  wire last_trail = trail_edge & (bit_cnt_next == char_bits);

  // ==========================================================
  // Register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_status_reg    <= TX_STATUS_RESET & TX_STATUS_WMASK;
      rx_status_reg    <= RX_STATUS_RESET;
      baud_divisor_reg <= BAUD_RESET;
      wake_ctrl_reg    <= WAKE_RESET;
    end
    else
    begin
      if (wr_txs)
        tx_status_reg <= pwdata[7:0] & TX_STATUS_WMASK;
      if (wr_rxs)
        rx_status_reg <= pwdata[7:0] & RX_STATUS_WMASK;
      if (wr_baud)
        baud_divisor_reg <= pwdata[7:0];
      if (wr_wake)
        wake_ctrl_reg <= pwdata[2:0];
    end
  end

  // ==========================================================
  // Transmit buffer: ninth bit captured with the low byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tbuf_reg      <= {1'b0, TX_BUFFER_RESET};
      tbuf_full_reg <= 1'b0;
    end
    else
    begin
      if (wr_tbuf)
      begin
        tbuf_reg      <= {ninth_transmit_bit, pwdata[7:0]};
        tbuf_full_reg <= 1'b1;
      end
      else if (load_tsr)
      begin
        tbuf_full_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Shift register, not reachable from the bus
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tsr_reg      <= 9'h000;
      tsr_busy_reg <= 1'b0;
      started_reg  <= 1'b0;
      bit_cnt_reg  <= 4'h0;
    end
    else if (!tx_on)
    begin
      tsr_busy_reg <= 1'b0;
      started_reg  <= 1'b0;
      bit_cnt_reg  <= 4'h0;
    end
    else if (load_tsr)
    begin
      tsr_reg      <= tbuf_reg;
      tsr_busy_reg <= 1'b1;
      started_reg  <= 1'b0;
      bit_cnt_reg  <= 4'h0;
    end
    else
    begin
      if (lead_edge)
      begin
        started_reg <= 1'b1;
        if (started_reg)
          tsr_reg <= {1'b0, tsr_reg[8:1]};
      end
      if (trail_edge)
      begin
        bit_cnt_reg <= bit_cnt_next;
        if (last_trail)
          tsr_busy_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Wake from halt on a rising buffer-empty flag
  wire flag_rise = transmit_buffer_empty_flag & ~flag_last_reg;
  wire wake_now  = halt_in & flag_rise & peripheral_interrupt_enable
                 & transmit_interrupt_enable;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_last_reg <= 1'b1;
      wake_reg      <= 1'b0;
      isr_call_reg  <= 1'b0;
    end
    else
    begin
      flag_last_reg <= transmit_buffer_empty_flag;
      wake_reg      <= wake_now;
      isr_call_reg  <= wake_now & global_interrupt_enable;
    end
  end

  assign wake_out     = wake_reg;
  assign isr_call_out = isr_call_reg;

  // ==========================================================
  // Read data, captured in the setup phase
  wire [7:0] tx_status_view = {tx_status_reg[7:2], shift_register_empty,
                               tx_status_reg[0]};
  wire [7:0] wake_view      = {3'h0, transmit_buffer_empty_flag, 1'b0, wake_ctrl_reg};
  wire [7:0] read_byte      = hit_txs  ? tx_status_view   :
                              hit_rxs  ? rx_status_reg    :
                              hit_baud ? baud_divisor_reg :
                              hit_wake ? wake_view        : 8'h00;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h0000_0000;
    else if (setup_phase)
      prdata_reg <= {24'h00_0000, read_byte};
  end

  assign prdata = prdata_reg;

  // ==========================================================
  // Pin drivers, enables active low
  assign clock_pin_out  = sc_bus.clk_level;
  assign clock_pin_oe_n = ~(unit_on & is_master);
  assign data_pin_out   = tsr_reg[0];
  assign data_pin_oe_n  = ~tx_on;

endmodule

// ==== rtl/sst_pkg.sv ====
// Package for the synchronous serial transmit unit: register map,
// field positions, reset values and shift clock constants.
// Assumes a 32-bit APB register bus with one register per aligned word.
package sst_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_TX_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_RX_STATUS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_TRANSMIT_BUFFER   = 8'h08;
  localparam logic [7:0] OFS_BAUD_DIVISOR      = 8'h0c;
  localparam logic [7:0] OFS_WAKE_CONTROL      = 8'h10;

  // ==========================================================
  // Transmit status/control fields
  localparam int TXS_CLOCK_SOURCE_MASTER = 7;
  localparam int TXS_NINE_BIT_SELECT     = 6;
  localparam int TXS_TRANSMIT_ENABLE     = 5;
  localparam int TXS_SYNC_MODE           = 4;
  localparam int TXS_HIGH_BAUD_SELECT    = 2;
  localparam int TXS_SHIFT_REG_EMPTY     = 1;
  localparam int TXS_NINTH_BIT           = 0;

  // Receive status/control fields
  localparam int RXS_SERIAL_PORT_ENABLE  = 7;
  localparam int RXS_SINGLE_RX_ENABLE    = 5;
  localparam int RXS_CONT_RX_ENABLE      = 4;
  localparam int RXS_ADDRESS_DETECT      = 3;

  // Wake control fields
  localparam int WKC_TX_INT_ENABLE       = 0;
  localparam int WKC_PERIPH_INT_ENABLE   = 1;
  localparam int WKC_GLOBAL_INT_ENABLE   = 2;
  localparam int WKC_BUFFER_EMPTY_FLAG   = 4;

  // ==========================================================
  // Reset values
  localparam logic [7:0] TX_STATUS_RESET = 8'h02;
  localparam logic [7:0] RX_STATUS_RESET = 8'h00;
  localparam logic [7:0] TX_BUFFER_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET      = 8'h00;
  localparam logic [2:0] WAKE_RESET      = 3'h0;

  // Writable masks (read-only and reserved bits excluded)
  localparam logic [7:0] TX_STATUS_WMASK = 8'hf5;
  localparam logic [7:0] RX_STATUS_WMASK = 8'hf8;

  // ==========================================================
  // Character lengths and shift clock prescale
  localparam logic [3:0] BITS_NORMAL     = 4'h8;
  localparam logic [3:0] BITS_NINE       = 4'h9;
  localparam int         LOW_SPEED_SHIFT = 2;

endpackage

// ==== rtl/shift_clock_if.sv ====
// Interface between the transmit core and the shift clock unit.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface shift_clock_if;
  logic       master;
  logic       busy;
  logic       halt;
  logic       high_baud;
  logic [7:0] divisor;
  logic       lead;
  logic       trail;
  logic       clk_level;

  modport core
  (
    output master,
    output busy,
    output halt,
    output high_baud,
    output divisor,
    input  lead,
    input  trail,
    input  clk_level
  );

  modport clk_side
  (
    input  master,
    input  busy,
    input  halt,
    input  high_baud,
    input  divisor,
    output lead,
    output trail,
    output clk_level
  );
endinterface

// ==== rtl/shift_clock_unit.sv ====
// Shift clock unit: makes the master shift clock from the baud divisor,
// or finds the edges of the clock pin in slave mode.
// Assumes the clock pin input is asynchronous to pclk and idles low.
`timescale 1ns/1ps
module shift_clock_unit
  import sst_pkg::*;
(
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  clock_pin_in,
  shift_clock_if.clk_side sc
);

  // ==========================================================
  // Slave clock synchroniser and edge finder
  logic        pin_meta_reg;
  logic        pin_sync_reg;
  logic        pin_last_reg;
  wire         slave_lead  = pin_sync_reg & ~pin_last_reg;
  wire         slave_trail = ~pin_sync_reg & pin_last_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_last_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= clock_pin_in;
      pin_sync_reg <= pin_meta_reg;
      pin_last_reg <= pin_sync_reg;
    end
  end

  // ==========================================================
  // Master divider: half period from divisor and speed select
  logic [10:0] half_cnt_reg;
  logic        clk_out_reg;
  wire  [10:0] div_plus   = {3'h0, sc.divisor} + 11'h001;
  wire  [10:0] half_count = sc.high_baud ? div_plus : 11'(div_plus << LOW_SPEED_SHIFT);
  wire         half_done  = (half_cnt_reg == half_count - 11'h001);
  wire         run_tick   = sc.master & sc.busy & ~sc.halt & half_done;
  // Edge strobes share the edge that moves the pin, so data and clock change together
  wire         m_lead     = run_tick & ~clk_out_reg;
  wire         m_trail    = run_tick & clk_out_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      half_cnt_reg <= 11'h000;
      clk_out_reg  <= 1'b0;
    end
    else
    begin
      if (!sc.master || !sc.busy)
      begin
        half_cnt_reg <= 11'h000;
        clk_out_reg  <= 1'b0;
      end
      else if (!sc.halt)
      begin
        if (half_done)
        begin
          half_cnt_reg <= 11'h000;
          clk_out_reg  <= ~clk_out_reg;
        end
        else
        begin
          half_cnt_reg <= half_cnt_reg + 11'h001;
        end
      end
    end
  end

  assign sc.lead      = sc.master ? m_lead : slave_lead;
  assign sc.trail     = sc.master ? m_trail : slave_trail;
  assign sc.clk_level = clk_out_reg;

endmodule

// ==== tb/sync_serial_tx_unit_props.sv ====
// Port checker for the synchronous serial transmit unit.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module sst_props
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        halt_in,
  input wire logic        wake_out,
  input wire logic        isr_call_out,
  input wire logic        clock_pin_in,
  input wire logic        clock_pin_out,
  input wire logic        clock_pin_oe_n,
  input wire logic        data_pin_in,
  input wire logic        data_pin_out,
  input wire logic        data_pin_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====
  // Shift clock and data
  sequence s_high_hold;
    clock_pin_out && $past(clock_pin_out);
  endsequence
  property p_clk_drv;
    $rose(clock_pin_out) |-> !clock_pin_oe_n;
  endproperty
  a_clk_drv: assert property (p_clk_drv) else $error("clock rose undriven");
  property p_clk_idle;
    clock_pin_oe_n [*3] |-> !clock_pin_out;
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("clock high while released");
  property p_bit_hold;
    s_high_hold |-> $stable(data_pin_out);
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("data moved in high phase");
  // ====
  // Wake
  property p_wake_pulse;
    wake_out |=> !wake_out;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
  property p_wake_halt;
    wake_out |-> $past(halt_in);
  endproperty
  a_wake_halt: assert property (p_wake_halt) else $error("wake without halt");
  property p_isr;
    isr_call_out |-> wake_out;
  endproperty
  a_isr: assert property (p_isr) else $error("routine call without wake");
  // ====
  // Register bus
  property p_err;
    pslverr |-> psel && penable;
  endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_hi_zero;
    psel && penable |-> prdata[31:8] == 24'h000000;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
endmodule

// ==== tb/remote_serial_peer.sv ====
// Remote synchronous peer: samples the data line on trailing edges
// and, as master of a slave unit, clocks frames at 125 ns.
`timescale 1ns/1ps
module remote_serial_peer
(
  input  wire logic clk_line,
  input  wire logic data_line,
  output logic      peer_clk
);
  logic [31:0] bits;
  int          cnt;
  realtime     t_fall;
  realtime     per;
  initial
  begin
    peer_clk = 1'b0;
    bits = '0;
    cnt = 0;
    t_fall = 0;
    per = 0;
  end
  // Data only, LSB first, taken at the trailing edge
  always @(negedge clk_line)
  begin
    bits[cnt[4:0]] <= data_line;
    cnt <= cnt + 1;
    per <= $realtime - t_fall;
    t_fall <= $realtime;
  end
  task clear();
    cnt = 0;
    bits = '0;
  endtask
  // Clock runs only within a frame and idles low
  task run(input int n);
    repeat (n)
    begin
      #62.5 peer_clk = 1'b1;
      #62.5 peer_clk = 1'b0;
    end
  endtask
endmodule

// ==== tb/tb_sync_serial_tx_unit.sv ====
// Self-checking bench for the synchronous serial transmit unit.
// Assumes the package, design, peer model and checker compile first.
`timescale 1ns/1ps
module tb_sync_serial_tx_unit;
  import sst_pkg::*;
  typedef struct packed
  {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic        e;
  } reg_row_t;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        halt_in;
  logic        wake_out;
  logic        isr_call_out;
  wire         clock_pin_in;
  logic        clock_pin_out;
  logic        clock_pin_oe_n;
  wire         data_pin_in;
  logic        data_pin_out;
  logic        data_pin_oe_n;
  logic        peer_clk;
  logic [31:0] rdat;
  logic        rerr;
  int          errors;
  int          checked;
  int          wakes;
  int          isrs;
  reg_row_t    rows [10];
  assign clock_pin_in = clock_pin_oe_n ? peer_clk : clock_pin_out;
  // Released data line is pulled up
  assign data_pin_in = data_pin_oe_n ? 1'b1 : data_pin_out;
  sync_serial_tx_unit u_dut
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .halt_in, .wake_out, .isr_call_out, .clock_pin_in, .clock_pin_out, .clock_pin_oe_n,
    .data_pin_in, .data_pin_out, .data_pin_oe_n
  );
  remote_serial_peer u_peer (.clk_line(clock_pin_in), .data_line(data_pin_in), .peer_clk(peer_clk));
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    if (wake_out === 1'b1)
      wakes++;
    if (isr_call_out === 1'b1)
      isrs++;
  end
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task drain(input int n, input logic [31:0] exp, input int per);
    for (int i = 0; i < 3000 && u_peer.cnt < n; i++)
      @(posedge pclk);
    repeat (40) @(posedge pclk);
    check("bit count", 32'(u_peer.cnt), 32'(n));
    check("bits", u_peer.bits, exp);
    check("period", 32'(int'(u_peer.per)), 32'(per));
    apb(1'b0, OFS_TX_STATUS_CONTROL, 32'h0);
    check("shift empty", 32'(rdat[TXS_SHIFT_REG_EMPTY]), 32'h1);
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    conclude();
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    halt_in = 1'b0;
    rows = '{'{1'b0, 8'h00, 32'h02, 1'b0}, '{1'b0, 8'h04, 32'h00, 1'b0}, '{1'b0, 8'h08, 32'h00, 1'b0},
             '{1'b0, 8'h0c, 32'h00, 1'b0}, '{1'b0, 8'h10, 32'h10, 1'b0}, '{1'b0, 8'h14, 32'h00, 1'b1},
             '{1'b1, 8'h00, 32'hff, 1'b0}, '{1'b0, 8'h00, 32'hf7, 1'b0}, '{1'b1, 8'h00, 32'h00, 1'b0},
             '{1'b1, 8'h14, 32'hff, 1'b1}};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      check("pslverr", 32'(rerr), 32'(rows[i].e));
      if (!rows[i].w)
        check("read", rdat, rows[i].d);
    end
    $display("test registers done");
    apb(1'b1, OFS_BAUD_DIVISOR, 32'h1);
    apb(1'b1, OFS_RX_STATUS_CONTROL, 32'h80);
    apb(1'b1, OFS_TX_STATUS_CONTROL, 32'hb4);
    u_peer.clear();
    apb(1'b1, OFS_TRANSMIT_BUFFER, 32'ha5);
    apb(1'b1, OFS_TRANSMIT_BUFFER, 32'h3c);
    drain(16, 32'h3ca5, 16);
    $display("test master done");
    apb(1'b1, OFS_BAUD_DIVISOR, 32'h0);
    apb(1'b1, OFS_TX_STATUS_CONTROL, 32'hf1);
    u_peer.clear();
    apb(1'b1, OFS_TRANSMIT_BUFFER, 32'h5a);
    drain(9, 32'h15a, 32);
    $display("test nine bit done");
    apb(1'b1, OFS_RX_STATUS_CONTROL, 32'h90);
    @(posedge pclk);
    check("data oe", 32'(data_pin_oe_n), 32'h1);
    check("clock oe", 32'(clock_pin_oe_n), 32'h0);
    apb(1'b1, OFS_RX_STATUS_CONTROL, 32'h00);
    @(posedge pclk);
    check("both oe", 32'({clock_pin_oe_n, data_pin_oe_n}), 32'h3);
    $display("test modes done");
    apb(1'b1, OFS_WAKE_CONTROL, 32'h07);
    apb(1'b1, OFS_RX_STATUS_CONTROL, 32'h80);
    apb(1'b1, OFS_TX_STATUS_CONTROL, 32'h34);
    u_peer.clear();
    apb(1'b1, OFS_TRANSMIT_BUFFER, 32'h81);
    apb(1'b1, OFS_TRANSMIT_BUFFER, 32'h7e);
    halt_in <= 1'b1;
    apb(1'b0, OFS_WAKE_CONTROL, 32'h0);
    check("flag", rdat, 32'h07);
    check("slave clock oe", 32'(clock_pin_oe_n), 32'h1);
    u_peer.run(16);
    drain(16, 32'h7e81, 125);
    check("wake", 32'(wakes), 32'h1);
    check("routine", 32'(isrs), 32'h1);
    halt_in <= 1'b0;
    $display("test slave done");
    conclude();
  end
endmodule
bind sync_serial_tx_unit sst_props u_props
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .halt_in, .wake_out, .isr_call_out, .clock_pin_in, .clock_pin_out, .clock_pin_oe_n,
  .data_pin_in, .data_pin_out, .data_pin_oe_n
);
